/* pkg/spi_front_pkg.sv */
// Purpose: shared constants and types of the serial command front end and power control
// Assumes: 25 MHz system clock
// Notes: opcode values are local encodings of the strobes and access commands
package spi_front_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 40;
	localparam int REG_SETTLE_NS = 100000;
	localparam int OSC_SETTLE_NS = 200000;
	// least times, rounded up
	localparam int REG_SETTLE_CYC = (REG_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int OSC_SETTLE_CYC_DEF = (OSC_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 13;

	// ----------------------------------------------------------------
	// instruction encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_OSC_START = 8'h01;
	localparam logic [7:0] OP_BIT_SET = 8'h04;
	localparam logic [7:0] OP_SOFT_RESET = 8'h0f;
	localparam logic [3:0] OP_MEM_RD_HI = 4'h1;
	localparam logic [3:0] OP_MEM_WR_HI = 4'h2;
	localparam int PARAM_ZERO_BIT = 7;
	localparam logic [11:0] ADDR_LAST = 12'hfff;
	localparam logic [11:0] ADDR_FIRST = 12'h000;

	localparam logic [1:0] CLS_BAD = 2'h0;
	localparam logic [1:0] CLS_STROBE = 2'h1;
	localparam logic [1:0] CLS_PARAM = 2'h2;
	localparam logic [1:0] CLS_STREAM = 2'h3;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		PWR_OFF = 6'h01,
		PWR_UNKNOWN = 6'h02,
		PWR_RST_HOLD = 6'h04,
		PWR_OSC_WAIT = 6'h08,
		PWR_ACTIVE = 6'h10,
		PWR_RETAIN = 6'h20
	} pwr_t;

	typedef enum logic [3:0] {
		CMD_OPCODE = 4'h1,
		CMD_PARAM = 4'h2,
		CMD_STREAM = 4'h4,
		CMD_HALT = 4'h8
	} cmd_t;
endpackage

/* hw/spi_byte_link.sv */
// Purpose: oversampled serial byte shifter, mode 0, msb first both ways
// Assumes: serial clock at most a quarter of mclk after synchronising
// Notes: all pin inputs pass two flops before use
`timescale 1ns/1ns
module spi_byte_link
	import spi_front_pkg::*;
(
	input logic mclk,
	input logic srst,
	input logic clk_en,
	input logic chip_select_n,
	input logic sclk,
	input logic mosi,
	input logic [7:0] tx_byte,
	input logic tx_load,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic frame_start,
	output logic frame_end,
	output logic mid_byte_end,
	output logic miso,
	output logic miso_oe
);
	logic [2:0] cs_s_q;
	logic [2:0] sck_s_q;
	logic [1:0] mosi_s_q;
	logic [2:0] bit_cnt_q;
	logic [6:0] rx_sh_q;
	logic [7:0] rx_byte_q;
	logic [7:0] tx_sh_q;
	logic rx_valid_q;
	logic start_q;
	logic end_q;
	logic mid_q;
	logic oe_q;
	logic cs_act;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;

	// [0] feeds only [1]; edges compare [1] and [2]
	assign cs_act = ~cs_s_q[1];
	assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
	assign sck_fall = ~sck_s_q[1] & sck_s_q[2];
	assign cs_rise = cs_s_q[1] & ~cs_s_q[2];

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			cs_s_q <= 3'h7;
			sck_s_q <= 3'h0;
			mosi_s_q <= 2'h0;
		end
		else if (clk_en)
		begin
			cs_s_q <= {cs_s_q[1:0], chip_select_n};
			sck_s_q <= {sck_s_q[1:0], sclk};
			mosi_s_q <= {mosi_s_q[0], mosi};
		end
	end

	// ----------------------------------------------------------------
	// receive side
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			bit_cnt_q <= 3'h0;
			rx_sh_q <= 7'h00;
			rx_byte_q <= 8'h00;
			rx_valid_q <= 1'b0;
		end
		else if (clk_en)
		begin
			rx_valid_q <= 1'b0;
			if (!cs_act)
				bit_cnt_q <= 3'h0;
			else if (sck_rise)
			begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
				rx_sh_q <= {rx_sh_q[5:0], mosi_s_q[1]}; // see [RL14]
				if (bit_cnt_q == 3'h7)
				begin
					rx_byte_q <= {rx_sh_q, mosi_s_q[1]};
					rx_valid_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// frame edges and transmit side
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			start_q <= 1'b0;
			end_q <= 1'b0;
			mid_q <= 1'b0;
			oe_q <= 1'b0;
			tx_sh_q <= 8'h00;
		end
		else if (clk_en)
		begin
			start_q <= ~cs_s_q[1] & cs_s_q[2];
			end_q <= cs_rise;
			mid_q <= cs_rise & (bit_cnt_q != 3'h0); // see [RL21]
			oe_q <= cs_act;
			// no shift after the last bit: next byte is loaded instead
			if (tx_load)
				tx_sh_q <= tx_byte;
			else if (sck_fall && cs_act && bit_cnt_q != 3'h0)
				tx_sh_q <= {tx_sh_q[6:0], 1'b0}; // see [RL14]
		end
	end

	assign rx_byte = rx_byte_q;
	assign rx_valid = rx_valid_q;
	assign frame_start = start_q;
	assign frame_end = end_q;
	assign mid_byte_end = mid_q;
	assign miso = tx_sh_q[7];
	assign miso_oe = oe_q;

	property p_msb_first;
		@(posedge mclk) disable iff (srst)
		clk_en && cs_act && sck_rise && bit_cnt_q == 3'h7 |=> rx_valid_q && rx_byte_q[0] == $past(mosi_s_q[1]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("last bit not in lsb"); // see [RL14]

	property p_mid_byte;
		@(posedge mclk) disable iff (srst)
		clk_en && cs_rise && bit_cnt_q != 3'h0 |=> mid_q ##1 !mid_q;
	endproperty
	a_mid_byte: assert property (p_mid_byte) else $error("mid byte end not flagged"); // see [RL21]
endmodule

/* hw/spi_command_front_and_power.sv */
// Purpose: instruction framing, error exceptions and power state control
// Assumes: memory answers rd_data in the cycle after mem_re
// Notes: osc settle count is a parameter so benches may shorten it
`timescale 1ns/1ns
// Overview of operation
// [RL1] deepest sleep: regulator off, clocks stopped, no data
// [RL2] retention: regulator on, clocks stopped, data kept
// [RL3] active: regulator on, oscillator runs, logic steers analog
// [RL4] host must reset after deepest sleep
// [RL5] host prefers pin reset over soft reset
// [RL6] host resets before entering deepest sleep
// [RL7] host waits regulator settle before reset release
// [RL8] oscillator needs settle time after start
// [RL9] pin held low drives pins to reset setup
// [RL10] soft reset only after regulator settled
// [RL11] soft reset leaves oscillator state untouched
// [RL12] host serial clock at most 8 MHz
// [RL13] first byte opcode, then parameter bytes
// [RL14] all bytes shifted most significant bit first
// [RL15] status byte returned unless read data
// [RL16] addresses little endian, increment wraps past 0xfff
// [RL17] instruction ends by length or select rise
// [RL18] incomplete or unknown instruction flags bad operand
// [RL19] forced-zero parameter bit set flags bad operand
// [RL20] after error ignore input until select cycles
// [RL21] select rising mid-byte flags serial error
// [RL22] lettered bits form one unsigned word
// [RL23] oscillator start first, then no-op required
// [RL24] track power state, ignore clocked commands early
module spi_command_front_and_power
	import spi_front_pkg::*;
#(
	parameter int OSC_SETTLE_CYC = OSC_SETTLE_CYC_DEF
)
(
	input logic mclk,
	input logic srst,
	input logic clk_en,
	input logic hw_reset_pin_n,
	input logic core_regulator_enable,
	input logic chip_select_n,
	input logic sclk,
	input logic mosi,
	input logic [7:0] status_byte,
	input logic [7:0] rd_data,
	input logic retention_req,
	input logic analog_pd_req,
	output logic miso,
	output logic miso_oe,
	output logic [5:0] pwr_state,
	output logic clocks_run,
	output logic osc_enable,
	output logic osc_stable,
	output logic analog_pd,
	output logic gpio_reset_cfg,
	output logic soft_reset_strobe,
	output logic bad_operand_flag,
	output logic spi_error_flag,
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [7:0] cmd_param,
	output logic mem_re,
	output logic mem_we,
	output logic [11:0] mem_addr,
	output logic [7:0] mem_wdata
);
	function automatic logic [1:0] op_class(input logic [7:0] op);
		if (op == OP_NOP || op == OP_OSC_START || op == OP_SOFT_RESET)
			return CLS_STROBE;
		else if (op == OP_BIT_SET)
			return CLS_PARAM;
		else if (op[7:4] == OP_MEM_RD_HI || op[7:4] == OP_MEM_WR_HI)
			return CLS_STREAM;
		else
			return CLS_BAD;
	endfunction

	pwr_t pwr_q, pwr_d;
	cmd_t cmd_q;
	logic [1:0] reg_s_q;
	logic [1:0] rstn_s_q;
	logic reg_s;
	logic rstn_s;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_lim;
	logic tmr_done;
	logic osc_en_q, osc_ok_q, clk_run_q, apd_q, gpio_q;
	logic soft_go, osc_go, err_op;
	logic soft_q, bad_q, spi_err_q;
	logic first_q, osc_pend_q, rd_mode_q, load_rd_q;
	logic [3:0] addr_hi_q;
	logic [7:0] op_q;
	logic cmd_v_q, re_q, we_q;
	logic [7:0] cmd_op_q, cmd_par_q, wdata_q;
	logic [11:0] addr_q;
	logic [7:0] rx_byte;
	logic rx_valid, frame_start, frame_end, mid_byte_end;
	logic read_next, tx_load;
	logic [7:0] tx_byte;
	logic [1:0] cls;
	logic awake;
	logic cmd_hold;

	spi_byte_link u_link (
		.mclk(mclk),
		.srst(srst),
		.clk_en(clk_en),
		.chip_select_n(chip_select_n),
		.sclk(sclk),
		.mosi(mosi),
		.tx_byte(tx_byte),
		.tx_load(tx_load),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid),
		.frame_start(frame_start),
		.frame_end(frame_end),
		.mid_byte_end(mid_byte_end),
		.miso(miso),
		.miso_oe(miso_oe)
	);

	// ----------------------------------------------------------------
	// pin synchronisers and settle timer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			reg_s_q <= 2'h0;
			rstn_s_q <= 2'h0;
		end
		else if (clk_en)
		begin
			reg_s_q <= {reg_s_q[0], core_regulator_enable};
			rstn_s_q <= {rstn_s_q[0], hw_reset_pin_n};
		end
	end
	assign reg_s = reg_s_q[1];
	assign rstn_s = rstn_s_q[1];

	assign tmr_lim = (pwr_q == PWR_OSC_WAIT) ? TMR_W'(OSC_SETTLE_CYC - 1) : TMR_W'(REG_SETTLE_CYC - 1);
	assign tmr_done = (tmr_q == tmr_lim);

	always_ff @(posedge mclk)
	begin
		if (srst)
			tmr_q <= '0;
		else if (clk_en)
		begin
			if (pwr_d != pwr_q || !reg_s)
				tmr_q <= '0;
			else if (!tmr_done)
				tmr_q <= tmr_q + TMR_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// power state
	// ----------------------------------------------------------------
	always_comb
	begin
		pwr_d = pwr_q;
		if (!reg_s)
			pwr_d = PWR_OFF; // see [RL1]
		else if (!rstn_s && pwr_q != PWR_OFF)
			pwr_d = PWR_RST_HOLD; // see [RL9]
		else
			case (pwr_q)
				PWR_OFF: if (tmr_done) pwr_d = PWR_UNKNOWN; // see [RL10]
				PWR_RST_HOLD: pwr_d = PWR_OSC_WAIT; // see [RL5]
				PWR_OSC_WAIT: if (tmr_done) pwr_d = PWR_ACTIVE; // see [RL8]
				PWR_ACTIVE: if (!soft_go && retention_req) pwr_d = PWR_RETAIN; // see [RL2]
				PWR_RETAIN: if (osc_go) pwr_d = PWR_OSC_WAIT;
				default: pwr_d = pwr_q;
			endcase
		// soft reset gives a known state but never starts the oscillator
		if (soft_go && reg_s && rstn_s && pwr_q != PWR_OFF)
			pwr_d = !osc_en_q ? PWR_RETAIN : (osc_ok_q ? PWR_ACTIVE : PWR_OSC_WAIT); // see [RL4]
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pwr_q <= PWR_OFF;
			clk_run_q <= 1'b0;
			apd_q <= 1'b1;
			gpio_q <= 1'b0;
		end
		else if (clk_en)
		begin
			pwr_q <= pwr_d;
			clk_run_q <= (pwr_d == PWR_ACTIVE); // see [RL3]
			gpio_q <= (pwr_d == PWR_RST_HOLD);
			if (pwr_d == PWR_OFF || pwr_d == PWR_UNKNOWN || pwr_d == PWR_RST_HOLD)
				apd_q <= 1'b1; // see [RL1]
			else
				apd_q <= analog_pd_req; // see [RL2]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			osc_en_q <= 1'b0;
			osc_ok_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (pwr_d == PWR_OFF || pwr_d == PWR_RETAIN)
			begin
				osc_en_q <= 1'b0;
				osc_ok_q <= 1'b0;
			end
			else if (pwr_d == PWR_RST_HOLD)
			begin
				osc_en_q <= 1'b1;
				osc_ok_q <= 1'b0;
			end
			else
			begin
				if (osc_go)
					osc_en_q <= 1'b1; // see [RL11]
				if (pwr_q == PWR_OSC_WAIT && tmr_done)
					osc_ok_q <= 1'b1; // see [RL8]
			end
		end
	end

	// ----------------------------------------------------------------
	// instruction framing
	// ----------------------------------------------------------------
	assign awake = (pwr_q == PWR_ACTIVE);
	assign cls = op_class(rx_byte);
	assign cmd_hold = (pwr_q == PWR_OFF) || (pwr_q == PWR_RST_HOLD);
	assign read_next = rd_mode_q && ((cmd_q == CMD_PARAM && op_class(op_q) == CLS_STREAM) || cmd_q == CMD_STREAM);
	// read data replaces the status byte
	assign tx_load = frame_start | (rx_valid & ~read_next) | load_rd_q; // see [RL15]
	assign tx_byte = load_rd_q ? rd_data : status_byte;
	assign soft_go = rx_valid && cmd_q == CMD_OPCODE && !err_op && rx_byte == OP_SOFT_RESET;
	assign osc_go = rx_valid && cmd_q == CMD_OPCODE && !err_op && rx_byte == OP_OSC_START;

	always_comb
	begin
		err_op = 1'b0;
		if (rx_valid && cmd_q == CMD_OPCODE)
			err_op = (osc_pend_q && rx_byte != OP_NOP) || cls == CLS_BAD || (rx_byte == OP_OSC_START && !first_q);
		else if (rx_valid && cmd_q == CMD_PARAM && op_q == OP_BIT_SET)
			err_op = rx_byte[PARAM_ZERO_BIT]; // see [RL19]
		else if (frame_end)
			err_op = cmd_q == CMD_PARAM || osc_pend_q; // see [RL18]
	end

	always_ff @(posedge mclk)
	begin
		if (srst || cmd_hold)
		begin
			cmd_q <= CMD_OPCODE;
			op_q <= OP_NOP;
			first_q <= 1'b1;
			osc_pend_q <= 1'b0;
			rd_mode_q <= 1'b0;
			addr_hi_q <= 4'h0;
		end
		else if (clk_en)
		begin
			if (frame_start || frame_end)
			begin
				cmd_q <= CMD_OPCODE; // see [RL17]
				first_q <= 1'b1;
				osc_pend_q <= 1'b0;
			end
			else if (rx_valid)
			begin
				if (err_op)
					cmd_q <= CMD_HALT; // see [RL20]
				else
					case (cmd_q)
						CMD_OPCODE:
						begin
							first_q <= 1'b0;
							op_q <= rx_byte; // see [RL13]
							osc_pend_q <= (rx_byte == OP_OSC_START); // see [RL23]
							addr_hi_q <= rx_byte[3:0];
							rd_mode_q <= (rx_byte[7:4] == OP_MEM_RD_HI);
							// clocked commands are halted unless the oscillator is stable (active state)
							if (cls != CLS_STROBE && !awake)
								cmd_q <= CMD_HALT; // see [RL24]
							else if (cls != CLS_STROBE)
								cmd_q <= CMD_PARAM;
						end
						CMD_PARAM: cmd_q <= (op_q == OP_BIT_SET) ? CMD_OPCODE : CMD_STREAM;
						default: cmd_q <= cmd_q;
					endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// command and memory outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst || cmd_hold)
		begin
			cmd_v_q <= 1'b0;
			cmd_op_q <= OP_NOP;
			cmd_par_q <= 8'h00;
			re_q <= 1'b0;
			we_q <= 1'b0;
			load_rd_q <= 1'b0;
			wdata_q <= 8'h00;
			addr_q <= ADDR_FIRST;
		end
		else if (clk_en)
		begin
			cmd_v_q <= 1'b0;
			re_q <= 1'b0;
			we_q <= 1'b0;
			load_rd_q <= re_q;
			if (we_q)
				addr_q <= (addr_q == ADDR_LAST) ? ADDR_FIRST : addr_q + 12'h001; // see [RL16]
			if (rx_valid && !err_op)
				case (cmd_q)
					CMD_OPCODE:
					begin
						if (cls == CLS_STROBE)
						begin
							cmd_v_q <= 1'b1;
							cmd_op_q <= rx_byte;
							cmd_par_q <= 8'h00;
						end
					end
					CMD_PARAM:
					begin
						if (op_q == OP_BIT_SET)
						begin
							cmd_v_q <= 1'b1;
							cmd_op_q <= op_q;
							cmd_par_q <= rx_byte;
						end
						else
						begin
							addr_q <= {addr_hi_q, rx_byte}; // see [RL22]
							re_q <= rd_mode_q;
						end
					end
					CMD_STREAM:
					begin
						if (rd_mode_q)
						begin
							addr_q <= (addr_q == ADDR_LAST) ? ADDR_FIRST : addr_q + 12'h001; // see [RL16]
							re_q <= 1'b1;
						end
						else
						begin
							we_q <= 1'b1;
							wdata_q <= rx_byte;
						end
					end
					default: cmd_v_q <= 1'b0;
				endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			soft_q <= 1'b0;
			bad_q <= 1'b0;
			spi_err_q <= 1'b0;
		end
		else if (clk_en)
		begin
			soft_q <= soft_go;
			bad_q <= err_op && !cmd_hold; // see [RL18]
			spi_err_q <= mid_byte_end; // see [RL21]
		end
	end

	assign pwr_state = pwr_q;
	assign clocks_run = clk_run_q;
	assign osc_enable = osc_en_q;
	assign osc_stable = osc_ok_q;
	assign analog_pd = apd_q;
	assign gpio_reset_cfg = gpio_q;
	assign soft_reset_strobe = soft_q;
	assign bad_operand_flag = bad_q;
	assign spi_error_flag = spi_err_q;
	assign cmd_valid = cmd_v_q;
	assign cmd_opcode = cmd_op_q;
	assign cmd_param = cmd_par_q;
	assign mem_re = re_q;
	assign mem_we = we_q;
	assign mem_addr = addr_q;
	assign mem_wdata = wdata_q;

	property p_off_dead;
		@(posedge mclk) disable iff (srst)
		pwr_q == PWR_OFF |-> !clk_run_q && apd_q && !osc_en_q;
	endproperty
	a_off_dead: assert property (p_off_dead) else $error("deep sleep not fully off"); // see [RL1]

	property p_retain_pd;
		@(posedge mclk) disable iff (srst)
		clk_en && pwr_d == PWR_RETAIN |=> !clk_run_q && apd_q == $past(analog_pd_req);
	endproperty
	a_retain_pd: assert property (p_retain_pd) else $error("retention controls wrong"); // see [RL2]

	property p_active_osc;
		@(posedge mclk) disable iff (srst)
		pwr_q == PWR_ACTIVE |-> clk_run_q && osc_en_q && osc_ok_q;
	endproperty
	a_active_osc: assert property (p_active_osc) else $error("active without stable osc"); // see [RL3]

	property p_osc_settle;
		@(posedge mclk) disable iff (srst)
		clk_en && pwr_q == PWR_OSC_WAIT && tmr_q < TMR_W'(OSC_SETTLE_CYC - 1) && !soft_go |=> pwr_q != PWR_ACTIVE;
	endproperty
	a_osc_settle: assert property (p_osc_settle) else $error("active before osc settled"); // see [RL8]

	property p_gpio_hold;
		@(posedge mclk) disable iff (srst)
		clk_en && reg_s && !rstn_s && pwr_q != PWR_OFF |=> gpio_q;
	endproperty
	a_gpio_hold: assert property (p_gpio_hold) else $error("pins not in reset setup"); // see [RL9]

	property p_soft_osc;
		@(posedge mclk) disable iff (srst)
		clk_en && soft_go && reg_s && rstn_s && pwr_q != PWR_OFF |=> osc_en_q == $past(osc_en_q) ##1 soft_q == 1'b0;
	endproperty
	a_soft_osc: assert property (p_soft_osc) else $error("soft reset changed osc"); // see [RL11]

	property p_zero_bit;
		@(posedge mclk) disable iff (srst)
		clk_en && !cmd_hold && rx_valid && cmd_q == CMD_PARAM && op_q == OP_BIT_SET && rx_byte[PARAM_ZERO_BIT]
			|=> bad_q && cmd_q == CMD_HALT;
	endproperty
	a_zero_bit: assert property (p_zero_bit) else $error("zero bit not flagged"); // see [RL19]

	property p_wrap;
		@(posedge mclk) disable iff (srst)
		clk_en && !cmd_hold && rx_valid && cmd_q == CMD_STREAM && rd_mode_q && addr_q == ADDR_LAST |=> addr_q == ADDR_FIRST && re_q;
	endproperty
	a_wrap: assert property (p_wrap) else $error("address did not wrap"); // see [RL16]
endmodule

/* tb/spi_host_model.sv */
// Purpose: host controller model driving the serial lines and power pins
// Assumes: caller waits on mclk falling edges
// Notes: serial clock idles low between frames
`timescale 1ns/1ns
module spi_host_model
(
	input logic mclk,
	input logic miso,
	output logic hw_reset_pin_n,
	output logic core_regulator_enable,
	output logic chip_select_n,
	output logic sclk,
	output logic mosi
);
	initial
	begin
		hw_reset_pin_n = 1'b1;
		core_regulator_enable = 1'b0;
		chip_select_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// caller waits out regulator settle before selecting
	task automatic pins(input logic reg_en, input logic pin_n);
		core_regulator_enable = reg_en;
		hw_reset_pin_n = pin_n;
	endtask

	// padding keeps sclk edges clear of select edges
	task automatic sel(input logic v);
		cyc(12);
		chip_select_n = v;
		cyc(12);
	endtask

	// half period of 4 mclk: 160 ns, period 320 ns, well under the 8 MHz ceiling
	task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			mosi = tx[i];
			cyc(4);
			rx[i] = miso;
			sclk = 1'b1;
			cyc(4);
			sclk = 1'b0;
		end
		// no stale bit left on the idle data line
		mosi = ~mosi;
		cyc(12);
	endtask
endmodule

/* tb/spi_command_front_and_power_tb_top.sv */
// Purpose: self-checking bench of command framing and power control
// Assumes: host model drives all pins, bench drives the rest at falling edges
// Notes: oscillator settle shortened to 50 cycles
`timescale 1ns/1ns
module spi_command_front_and_power_tb_top
	import spi_front_pkg::*;
;
	localparam int OSC_N = 50;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic retention_req = 1'b0;
	logic analog_pd_req = 1'b1;
	logic [7:0] status_byte = 8'h00;
	logic [7:0] rd_data = 8'h00;
	logic hw_reset_pin_n, core_regulator_enable, chip_select_n, sclk, mosi, miso, miso_oe;
	logic clocks_run, osc_enable, osc_stable, analog_pd, gpio_reset_cfg, soft_reset_strobe;
	logic bad_operand_flag, spi_error_flag, cmd_valid, mem_re, mem_we;
	logic [5:0] pwr_state;
	logic [7:0] cmd_opcode, cmd_param, mem_wdata, rx, d;
	logic [11:0] mem_addr, a;
	logic [23:0] obs;
	logic [23:0] exp_q[$];
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;

	spi_command_front_and_power #(.OSC_SETTLE_CYC(OSC_N)) dut_u (.mclk(mclk), .srst(srst), .clk_en(clk_en),
		.hw_reset_pin_n(hw_reset_pin_n), .core_regulator_enable(core_regulator_enable),
		.chip_select_n(chip_select_n), .sclk(sclk), .mosi(mosi), .status_byte(status_byte), .rd_data(rd_data),
		.retention_req(retention_req), .analog_pd_req(analog_pd_req), .miso(miso), .miso_oe(miso_oe),
		.pwr_state(pwr_state), .clocks_run(clocks_run), .osc_enable(osc_enable), .osc_stable(osc_stable),
		.analog_pd(analog_pd), .gpio_reset_cfg(gpio_reset_cfg), .soft_reset_strobe(soft_reset_strobe),
		.bad_operand_flag(bad_operand_flag), .spi_error_flag(spi_error_flag), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .cmd_param(cmd_param), .mem_re(mem_re), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata));

	spi_host_model host_u (.mclk(mclk), .miso(miso), .hw_reset_pin_n(hw_reset_pin_n),
		.core_regulator_enable(core_regulator_enable), .chip_select_n(chip_select_n), .sclk(sclk), .mosi(mosi));

	initial
	begin
		forever #20 mclk = ~mclk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic note(input logic [23:0] e);
		exp_q.push_back(e);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic xb(input logic [7:0] b);
		host_u.bits(b, 8, rx);
	endtask

	task automatic st(input pwr_t e);
		chk({18'h0, pwr_state}, {18'h0, e});
	endtask

	task automatic wait_st(input pwr_t e, input int lo, input int hi);
		int n;
		n = 0;
		while (pwr_state !== e && n < hi)
		begin
			cyc(1);
			n++;
		end
		chk({23'h0, n >= lo && n < hi}, 24'h1);
	endtask

	function automatic logic [23:0] cw(input logic [7:0] o, input logic s);
		return {4'h1, 3'h0, s, o, 8'h00};
	endfunction

	task automatic osc_on();
		host_u.sel(1'b0);
		note(cw(OP_OSC_START, 1'b0));
		xb(OP_OSC_START);
		note(cw(OP_NOP, 1'b0));
		xb(OP_NOP);
		host_u.sel(1'b1);
	endtask

	// memory answers the cycle after a read request
	always @(negedge mclk)
		rd_data <= mem_addr[7:0] ^ 8'h5a;

	// every pulse must match the oldest noted result; a stray one meets an impossible note
	always @(negedge mclk)
	begin
		if (cmd_valid | mem_we | mem_re | bad_operand_flag | spi_error_flag)
		begin
			obs = cmd_valid ? {4'h1, 3'h0, soft_reset_strobe, cmd_opcode, cmd_param} :
				mem_we ? {4'h2, mem_addr, mem_wdata} : mem_re ? {4'h3, mem_addr, 8'h00} :
				bad_operand_flag ? 24'h400000 : 24'h500000;
			chk(obs, exp_q.size() > 0 ? exp_q.pop_front() : 24'hffffff);
		end
	end

	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'h443e));
		status_byte = 8'($urandom);
		cyc(2);
		srst = 1'b0;
		cyc(4);
		host_u.pins(1'b1, 1'b1);
		cyc(REG_SETTLE_CYC + 8);
		st(PWR_UNKNOWN);
		chk({23'h0, analog_pd}, 24'h1);
		host_u.sel(1'b0);
		xb({OP_MEM_WR_HI, 4'h0});
		xb(8'h10);
		xb(8'haa);
		host_u.sel(1'b1);
		host_u.pins(1'b1, 1'b0);
		cyc(6);
		st(PWR_RST_HOLD);
		chk({23'h0, gpio_reset_cfg}, 24'h1);
		host_u.pins(1'b1, 1'b1);
		// enable low must freeze synchronisers and power state alike
		clk_en = 1'b0;
		cyc(20);
		st(PWR_RST_HOLD);
		clk_en = 1'b1;
		wait_st(PWR_ACTIVE, OSC_N, OSC_N + 10);
		chk({22'h0, clocks_run, osc_stable}, 24'h3);
		repeat (4)
		begin
			analog_pd_req = 1'($urandom);
			cyc(2);
			chk({23'h0, analog_pd}, {23'h0, analog_pd_req});
		end
		$display("test power done");
		status_byte = 8'($urandom);
		host_u.sel(1'b0);
		chk({23'h0, miso_oe}, 24'h1);
		note(cw(OP_NOP, 1'b0));
		xb(OP_NOP);
		chk({16'h0, rx}, {16'h0, status_byte});
		d = 8'($urandom) & 8'h7f;
		xb(OP_BIT_SET);
		note({4'h1, 4'h0, OP_BIT_SET, d});
		xb(d);
		xb(OP_BIT_SET);
		note(24'h400000);
		xb(d | 8'h80);
		xb(OP_NOP);
		host_u.sel(1'b1);
		host_u.sel(1'b0);
		note(24'h400000);
		xb(8'hc3);
		host_u.sel(1'b1);
		host_u.sel(1'b0);
		xb(OP_BIT_SET);
		note(24'h400000);
		host_u.sel(1'b1);
		host_u.sel(1'b0);
		note(24'h500000);
		host_u.bits(8'hff, 3, rx);
		host_u.sel(1'b1);
		chk({23'h0, miso_oe}, 24'h0);
		$display("test framing done");
		host_u.sel(1'b0);
		xb({OP_MEM_WR_HI, 4'hf});
		xb(8'hfe);
		for (int i = 0; i < 3; i++)
		begin
			d = 8'($urandom);
			note({4'h2, 12'hffe + 12'(i), d});
			xb(d);
		end
		host_u.sel(1'b1);
		host_u.sel(1'b0);
		xb({OP_MEM_RD_HI, 4'hf});
		note({4'h3, 12'hfff, 8'h00});
		xb(8'hff);
		for (int i = 0; i < 2; i++)
		begin
			a = 12'hfff + 12'(i);
			note({4'h3, a + 12'h001, 8'h00});
			xb(8'h00);
			chk({16'h0, rx}, {16'h0, a[7:0] ^ 8'h5a});
		end
		host_u.sel(1'b1);
		$display("test memory done");
		host_u.sel(1'b0);
		note(cw(OP_SOFT_RESET, 1'b1));
		xb(OP_SOFT_RESET);
		host_u.sel(1'b1);
		st(PWR_ACTIVE);
		chk({23'h0, osc_enable}, 24'h1);
		osc_on();
		host_u.sel(1'b0);
		note(cw(OP_NOP, 1'b0));
		xb(OP_NOP);
		note(24'h400000);
		xb(OP_OSC_START);
		host_u.sel(1'b1);
		$display("test strobes done");
		retention_req = 1'b1;
		cyc(6);
		st(PWR_RETAIN);
		chk({22'h0, clocks_run, analog_pd}, {23'h0, analog_pd_req});
		retention_req = 1'b0;
		// soft reset with the oscillator off must not start it
		host_u.sel(1'b0);
		note(cw(OP_SOFT_RESET, 1'b1));
		xb(OP_SOFT_RESET);
		host_u.sel(1'b1);
		st(PWR_RETAIN);
		chk({23'h0, osc_enable}, 24'h0);
		osc_on();
		wait_st(PWR_ACTIVE, 0, 4);
		host_u.pins(1'b1, 1'b0);
		cyc(6);
		host_u.pins(1'b0, 1'b1);
		cyc(6);
		st(PWR_OFF);
		chk({22'h0, clocks_run, analog_pd}, 24'h1);
		host_u.pins(1'b1, 1'b1);
		cyc(REG_SETTLE_CYC + 8);
		osc_on();
		host_u.sel(1'b0);
		note(cw(OP_SOFT_RESET, 1'b1));
		xb(OP_SOFT_RESET);
		host_u.sel(1'b1);
		wait_st(PWR_ACTIVE, 0, OSC_N + 30);
		$display("test modes done");
		chk({8'h0, 16'(exp_q.size())}, 24'h0);
		report_and_stop();
	end
endmodule
